/* File: lta_defines.svh */
// Purpose: constants for the line termination activation state machine
// Assumes: 100 MHz core clock
// Notes on behaviour
// - Deactivated state keeps the line transmitter silent.
// - Received SIG 1W while deactivated: answer SIG 2W, SIG 2 after awake-repeat timer.
// - Exchange activation request FE 1: send SIG 2W, await SIG 1W.
// - After wake-up, send SIG 2 and lock receiver on SIG 1 or SIG 3.
// - Receiver locked and SIG 1 seen: report FE 3.
// - Line synchronised both ways: wait for SIG 3.
// - Line and user side synchronised: send SIG 4H until hold timer expires.
// - Fully active: send SIG 4, report FE 4, channels carry traffic.
// - Pending deactivation sends SIG 0; SIG 0 back returns idle, reports FE 6.
// - Loopback 1 request FE 9: send SIG 2W, close loop 1 with SIG 2 after start timer.
// - Loopback 1 closed: receiver locks on own looped-back signal.
// - Loopback path after lock: send SIG 4H until hold timer expires.
// - Loopback fully active: send SIG 4, loopback 1 stays operated.
// - Loopback 2 and 1A requests change no state; passed to control channel.
// - Activation after deactivation within 210 ms, 420 ms with regenerator.
// - Activation after first power-up within 1,5 s, 3 s with regenerator.
// - Awake-repeat timer lasts 7 ms.
// - Hold timer for SIG 4H lasts 1 ms.
// - Loopback start timer lasts 12 ms.
`ifndef LTA_DEFINES_SVH
`define LTA_DEFINES_SVH

`define LTA_CLK_PERIOD_NS 10
`define LTA_NS_PER_MS 1000000
`define LTA_MS_CYC (`LTA_NS_PER_MS / `LTA_CLK_PERIOD_NS)
`define LTA_DIV_W 17
`define LTA_MS_W 12
`define LTA_AWAKE_REPEAT_MS 12'h007
`define LTA_HOLD_TONE_MS 12'h001
`define LTA_LOOPBACK_START_MS 12'h00C
`define LTA_ACT_REDO_MS 12'h0D2
`define LTA_ACT_REDO_REGEN_MS 12'h1A4
`define LTA_ACT_FIRST_MS 12'h5DC
`define LTA_ACT_FIRST_REGEN_MS 12'hBB8

`endif

/* File: lta_pkg.sv */
// Purpose: types for the line termination activation state machine
// Assumes: lta_defines.svh holds the numbers
// Notes: signals travel as packed structs
package lta_pkg;

  typedef enum logic [2:0] {
    LTA_RX_SIG0,
    LTA_RX_SIG1W,
    LTA_RX_SIG1,
    LTA_RX_SIG3,
    LTA_RX_OTHER
  } lta_rx_code_t;

  typedef enum logic [2:0] {
    LTA_TX_SIG0,
    LTA_TX_SIG2W,
    LTA_TX_SIG2,
    LTA_TX_SIG4H,
    LTA_TX_SIG4
  } lta_tx_code_t;

  typedef enum {
    ST_IDLE,
    ST_AWAKE_ANS,
    ST_AWAKE_REQ,
    ST_SYNC,
    ST_WAIT_SIG3,
    ST_HOLD,
    ST_ACTIVE,
    ST_PEND,
    ST_LB_WAKE,
    ST_LB_SYNC,
    ST_LB_HOLD,
    ST_LB_ACTIVE
  } lta_state_t;

  typedef struct packed {
    logic vld;
    lta_rx_code_t code;
  } lta_rx_t;

  typedef struct packed {
    logic en;
    lta_tx_code_t code;
  } lta_tx_t;

  typedef struct packed {
    logic fe1;
    logic fe5;
    logic fe9;
    logic lb2;
    logic lb1a;
  } lta_req_t;

  typedef struct packed {
    logic fe2;
    logic fe3;
    logic fe4;
    logic fe6;
    logic fe7;
  } lta_ind_t;

endpackage

/* File: lta_core.sv */
// Purpose: activation and deactivation state machine of a line termination
// Assumes: receiver detector and exchange logic run on core_clk
// Notes: one shared millisecond timer for the state steps, since only one of them runs at a time
`include "lta_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module lta_core #(
  parameter int MS_CYC = `LTA_MS_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire lta_pkg::lta_rx_t rx_i,
  input wire logic rx_lock_i,
  input wire logic rx_frame_lost_i,
  input wire logic loop_sync_i,
  input wire logic regen_pin_i,
  input wire lta_pkg::lta_req_t req_i,
  output lta_pkg::lta_tx_t tx_o,
  output lta_pkg::lta_ind_t ind_o,
  output logic loop1_o,
  output logic traffic_o,
  output logic ctl_lb2_o,
  output logic ctl_lb1a_o,
  output logic act_late_o
);
  import lta_pkg::*;

  localparam logic [`LTA_DIV_W-1:0] DIV_LAST = `LTA_DIV_W'(MS_CYC - 1);

  lta_state_t state_r;
  lta_state_t state_nxt;
  logic [`LTA_DIV_W-1:0] div_r;
  logic [`LTA_MS_W-1:0] ms_left_r;
  logic tmr_load;
  logic [`LTA_MS_W-1:0] tmr_val;
  logic tmr_exp;
  logic tick;
  lta_ind_t ind_nxt;
  logic regen_s1_r;
  logic regen_s2_r;
  logic first_r;
  logic [`LTA_DIV_W-1:0] act_div_r;
  logic [`LTA_MS_W-1:0] act_ms_r;
  logic [`LTA_MS_W-1:0] act_lim;

  function automatic logic is_sig(lta_rx_t r, lta_rx_code_t c);
    return r.vld && (r.code == c);
  endfunction

  function automatic lta_tx_t tx_of(lta_state_t s);
    lta_tx_t t;
    t.en = 1'b1;
    case (s)
      ST_IDLE:
      begin
        t.en = 1'b0;
        t.code = LTA_TX_SIG0;
      end
      ST_AWAKE_ANS, ST_AWAKE_REQ, ST_LB_WAKE: t.code = LTA_TX_SIG2W;
      ST_SYNC, ST_WAIT_SIG3, ST_LB_SYNC: t.code = LTA_TX_SIG2;
      ST_HOLD, ST_LB_HOLD: t.code = LTA_TX_SIG4H;
      ST_ACTIVE, ST_LB_ACTIVE: t.code = LTA_TX_SIG4;
      default: t.code = LTA_TX_SIG0;
    endcase
    return t;
  endfunction

  // Shared timer: restart also clears the divider so each run is exact
  assign tick = (div_r == DIV_LAST);
  assign tmr_exp = tick && (ms_left_r == `LTA_MS_W'(1));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      div_r <= '0;
      ms_left_r <= '0;
    end
    else if (tmr_load)
    begin
      div_r <= '0;
      ms_left_r <= tmr_val;
    end
    else if (ms_left_r != '0)
    begin
      div_r <= tick ? '0 : div_r + `LTA_DIV_W'(1);
      if (tick)
        ms_left_r <= ms_left_r - `LTA_MS_W'(1);
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    ind_nxt = '0;
    case (state_r)
      ST_IDLE:
      begin
        if (req_i.fe9)
        begin
          tmr_load = 1'b1;
          tmr_val = `LTA_LOOPBACK_START_MS;
          state_nxt = ST_LB_WAKE;
        end
        else if (is_sig(rx_i, LTA_RX_SIG1W))
        begin
          tmr_load = 1'b1;
          tmr_val = `LTA_AWAKE_REPEAT_MS;
          ind_nxt.fe2 = 1'b1;
          state_nxt = ST_AWAKE_ANS;
        end
        else if (req_i.fe1)
          state_nxt = ST_AWAKE_REQ;
      end
      ST_AWAKE_ANS:
      begin
        if (is_sig(rx_i, LTA_RX_SIG1W))
        begin
          tmr_load = 1'b1;
          tmr_val = `LTA_AWAKE_REPEAT_MS;
        end
        else if (tmr_exp)
          state_nxt = ST_SYNC;
      end
      ST_AWAKE_REQ:
        if (is_sig(rx_i, LTA_RX_SIG1W))
        begin
          ind_nxt.fe2 = 1'b1;
          state_nxt = ST_SYNC;
        end
      ST_SYNC:
        if (rx_lock_i && is_sig(rx_i, LTA_RX_SIG1))
        begin
          ind_nxt.fe3 = 1'b1;
          state_nxt = ST_WAIT_SIG3;
        end
        else if (rx_lock_i && is_sig(rx_i, LTA_RX_SIG3))
        begin
          tmr_load = 1'b1;
          tmr_val = `LTA_HOLD_TONE_MS;
          state_nxt = ST_HOLD;
        end
      ST_WAIT_SIG3:
        if (rx_frame_lost_i)
        begin
          ind_nxt.fe7 = 1'b1;
          state_nxt = ST_SYNC;
        end
        else if (is_sig(rx_i, LTA_RX_SIG3))
        begin
          tmr_load = 1'b1;
          tmr_val = `LTA_HOLD_TONE_MS;
          state_nxt = ST_HOLD;
        end
      ST_HOLD:
        if (rx_frame_lost_i)
        begin
          ind_nxt.fe7 = 1'b1;
          state_nxt = ST_SYNC;
        end
        else if (tmr_exp)
        begin
          ind_nxt.fe4 = 1'b1;
          state_nxt = ST_ACTIVE;
        end
      ST_ACTIVE:
        if (rx_frame_lost_i)
        begin
          ind_nxt.fe7 = 1'b1;
          state_nxt = ST_SYNC;
        end
      ST_PEND:
        if (is_sig(rx_i, LTA_RX_SIG0))
        begin
          ind_nxt.fe6 = 1'b1;
          state_nxt = ST_IDLE;
        end
      ST_LB_WAKE:
        if (tmr_exp)
          state_nxt = ST_LB_SYNC;
      ST_LB_SYNC:
        if (loop_sync_i)
        begin
          tmr_load = 1'b1;
          tmr_val = `LTA_HOLD_TONE_MS;
          state_nxt = ST_LB_HOLD;
        end
      ST_LB_HOLD:
        if (rx_frame_lost_i)
        begin
          ind_nxt.fe7 = 1'b1;
          state_nxt = ST_LB_SYNC;
        end
        else if (tmr_exp)
        begin
          ind_nxt.fe4 = 1'b1;
          state_nxt = ST_LB_ACTIVE;
        end
      ST_LB_ACTIVE:
        if (rx_frame_lost_i)
        begin
          ind_nxt.fe7 = 1'b1;
          state_nxt = ST_LB_SYNC;
        end
      default: state_nxt = state_r;
    endcase
    // Deactivation request overrides any activation step except leaving idle
    if (req_i.fe5 && state_r != ST_IDLE && state_r != ST_PEND)
    begin
      state_nxt = ST_PEND;
      tmr_load = 1'b0;
      ind_nxt = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Outputs follow the next state so they change with the state
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tx_o <= '{en: 1'b0, code: LTA_TX_SIG0};
      loop1_o <= 1'b0;
      traffic_o <= 1'b0;
      ind_o <= '0;
    end
    else
    begin
      tx_o <= tx_of(state_nxt);
      loop1_o <= (state_nxt == ST_LB_SYNC) || (state_nxt == ST_LB_HOLD) ||
                 (state_nxt == ST_LB_ACTIVE);
      traffic_o <= (state_nxt == ST_ACTIVE) ||
                   (state_nxt == ST_LB_ACTIVE);
      ind_o <= ind_nxt;
    end
  end

  // Loopback 2 and 1A only go out on the control channel
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ctl_lb2_o <= 1'b0;
      ctl_lb1a_o <= 1'b0;
    end
    else
    begin
      ctl_lb2_o <= req_i.lb2;
      ctl_lb1a_o <= req_i.lb1a;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      regen_s1_r <= 1'b0;
      regen_s2_r <= 1'b0;
    end
    else
    begin
      regen_s1_r <= regen_pin_i;
      regen_s2_r <= regen_s1_r;
    end
  end

  // Activation time supervision; flags late, cannot force the far end
  always_comb
  begin
    if (first_r)
      act_lim = regen_s2_r ? `LTA_ACT_FIRST_REGEN_MS : `LTA_ACT_FIRST_MS;
    else
      act_lim = regen_s2_r ? `LTA_ACT_REDO_REGEN_MS : `LTA_ACT_REDO_MS;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      first_r <= 1'b1;
    else if (state_r == ST_ACTIVE)
      first_r <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || state_r == ST_IDLE || state_r == ST_PEND ||
        state_r == ST_ACTIVE || state_r == ST_LB_ACTIVE)
    begin
      act_div_r <= '0;
      act_ms_r <= '0;
    end
    else if (act_div_r == DIV_LAST)
    begin
      act_div_r <= '0;
      if (act_ms_r != act_lim)
        act_ms_r <= act_ms_r + `LTA_MS_W'(1);
    end
    else
      act_div_r <= act_div_r + `LTA_DIV_W'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || state_r == ST_IDLE)
      act_late_o <= 1'b0;
    else if (act_ms_r == act_lim)
      act_late_o <= 1'b1;
  end

  // Checking helpers
  localparam int HOLD_CYC = int'(`LTA_HOLD_TONE_MS) * MS_CYC;
  localparam int LBS_CYC = int'(`LTA_LOOPBACK_START_MS) * MS_CYC;
  int cyc_r;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || state_nxt != state_r)
      cyc_r <= 1;
    else
      cyc_r <= cyc_r + 1;
  end

  AST_IDLE_SILENT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ind_o.fe6 |-> !tx_o.en && state_r == ST_IDLE)
    else $error("transmitter active after return to idle");

  AST_AWAKE_REPLY: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_IDLE && is_sig(rx_i, LTA_RX_SIG1W) && !req_i.fe9)
    |=> tx_o.en && tx_o.code == LTA_TX_SIG2W)
    else $error("no SIG 2W answer to SIG 1W");

  AST_AWAKE_RESTART: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_AWAKE_ANS && is_sig(rx_i, LTA_RX_SIG1W) && !req_i.fe5)
    |=> ms_left_r == `LTA_AWAKE_REPEAT_MS && div_r == '0)
    else $error("awake-repeat timer not restarted");

  AST_FE1_WAKE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_IDLE && req_i.fe1 && !req_i.fe9 && !rx_i.vld)
    |=> state_r == ST_AWAKE_REQ && tx_o.code == LTA_TX_SIG2W)
    else $error("FE 1 did not start wake-up");

  AST_SYNC_TX: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_AWAKE_REQ && is_sig(rx_i, LTA_RX_SIG1W) && !req_i.fe5)
    |=> tx_o.code == LTA_TX_SIG2 ##1 tx_o.code == LTA_TX_SIG2)
    else $error("SIG 2 not sent after wake-up");

  AST_FE3: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_SYNC && rx_lock_i && is_sig(rx_i, LTA_RX_SIG1) &&
     !req_i.fe5) |=> ind_o.fe3 ##1 !ind_o.fe3)
    else $error("FE 3 not reported once");

  AST_WAIT_SIG3: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_WAIT_SIG3 && !is_sig(rx_i, LTA_RX_SIG3) && !req_i.fe5 &&
     !rx_frame_lost_i) |=> state_r == ST_WAIT_SIG3)
    else $error("left SIG 3 wait without SIG 3");

  AST_HOLD_LEN: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_HOLD && state_nxt == ST_ACTIVE) |-> cyc_r == HOLD_CYC)
    else $error("SIG 4H duration wrong");

  AST_ACTIVE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (ind_o.fe4 && state_r == ST_ACTIVE) |-> tx_o.code == LTA_TX_SIG4 &&
    traffic_o)
    else $error("active state without SIG 4");

  AST_DEACT: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_PEND && is_sig(rx_i, LTA_RX_SIG0)) |=> ind_o.fe6 &&
    !tx_o.en)
    else $error("no FE 6 after SIG 0");

  AST_LB_START: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_LB_WAKE && state_nxt == ST_LB_SYNC) |-> cyc_r == LBS_CYC)
    else $error("loopback start timer wrong");

  AST_LB_HOLD: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_LB_SYNC && loop_sync_i && !req_i.fe5) |=>
    tx_o.code == LTA_TX_SIG4H && loop1_o)
    else $error("no SIG 4H after loop lock");

  AST_LB_ACTIVE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (state_r == ST_LB_HOLD && tmr_exp && !req_i.fe5 && !rx_frame_lost_i)
    |=> tx_o.code == LTA_TX_SIG4 && loop1_o && ind_o.fe4)
    else $error("loopback active state wrong");

  // Lock level alone moves no state, so it is left out of the trigger
  AST_LB2_NO_MOVE: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (req_i.lb2 && !req_i.fe1 && !req_i.fe5 && !req_i.fe9 && !rx_i.vld &&
     !tmr_exp && !rx_frame_lost_i && !loop_sync_i)
    |=> ctl_lb2_o && $stable(state_r))
    else $error("loopback 2 request moved the state");

  CV_ACTIVATE: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_r == ST_HOLD ##1 state_r == ST_ACTIVE);
  CV_DEACTIVATE: cover property (@(posedge core_clk) disable iff (sys_rst)
    ind_o.fe6);
  CV_LOOP: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_r == ST_LB_ACTIVE);
  CV_RESTART: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_r == ST_AWAKE_ANS && is_sig(rx_i, LTA_RX_SIG1W));

endmodule

`default_nettype wire

/* File: lta_nt_model.sv */
// Purpose: remote network termination model facing the line termination
// Assumes: acts on falling edges; delays counted in core_clk cycles
// Notes: answers wake, sync and deactivation; closes loop sync if looped
`timescale 1ns/100ps
`default_nettype none

module lta_nt_model (
  input wire logic core_clk,
  input wire lta_pkg::lta_tx_t tx_i,
  input wire logic loop1_i,
  input wire logic mute,
  input wire logic [3:0] dly,
  output var lta_pkg::lta_rx_t rx_o,
  output var logic rx_lock_o,
  output var logic loop_sync_o
);
  import lta_pkg::*;
  int wake_cnt = 0;
  lta_tx_t seen;
  logic lp;

  task automatic pause();
    repeat (dly) @(negedge core_clk);
  endtask

  task automatic pulse(input lta_rx_code_t c);
    rx_o = {1'b1, c};
    @(negedge core_clk);
    // Idle code keeps moving so a stale code never looks valid
    rx_o = {1'b0, lta_rx_code_t'(~c)};
  endtask

  initial
  begin
    rx_o = {1'b0, LTA_RX_OTHER};
    rx_lock_o = 1'b0;
    loop_sync_o = 1'b0;
    seen = '0;
    forever
    begin
      @(negedge core_clk);
      if (wake_cnt != 0)
      begin
        // Repeated awake signal, one every 20 cycles
        repeat (wake_cnt)
        begin
          pulse(LTA_RX_SIG1W);
          repeat (19) @(negedge core_clk);
        end
        wake_cnt = 0;
        seen = tx_i;
      end
      if (!loop1_i)
        loop_sync_o = 1'b0;
      if (tx_i !== seen)
      begin
        seen = tx_i;
        lp = loop1_i;
        pause();
        if (lp)
          loop_sync_o = 1'b1;
        else if (seen.en && seen.code == LTA_TX_SIG0)
        begin
          rx_lock_o = 1'b0;
          pulse(LTA_RX_SIG0);
        end
        else if (seen.en && seen.code == LTA_TX_SIG2W && !mute)
          pulse(LTA_RX_SIG1W);
        else if (seen.en && seen.code == LTA_TX_SIG2 && !mute)
        begin
          rx_lock_o = 1'b1;
          pulse(LTA_RX_SIG1);
          pause();
          pulse(LTA_RX_SIG3);
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: line_term_activation_fsm_tb.sv */
// Purpose: self-checking bench for the line termination activation machine
// Assumes: MS_CYC shortened to 8 cycles per ms
// Notes: expected output changes are queued ahead of each stimulus
`timescale 1ns/100ps
`default_nettype none

module line_term_activation_fsm_tb;
  import lta_pkg::*;
  localparam int MS = 8;
  logic core_clk;
  logic sys_rst;
  logic regen_pin;
  logic rx_frame_lost;
  logic mute;
  logic [3:0] dly;
  lta_req_t req;
  lta_rx_t rx;
  logic rx_lock;
  logic loop_sync;
  lta_tx_t tx;
  lta_ind_t ind;
  logic loop1;
  logic traffic;
  logic ctl_lb2;
  logic ctl_lb1a;
  logic act_late;
  int errors = 0;
  int tests_run = 0;
  int seed = 32'hB3F6;
  int cyc = 0;
  int last = 0;
  int mon_gap;
  int i;
  lta_tx_t prev_tx = '0;
  logic [10:0] exp_q[$];
  int gap_q[$];

  lta_core #(.MS_CYC(MS)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .rx_i(rx),
    .rx_lock_i(rx_lock), .rx_frame_lost_i(rx_frame_lost),
    .loop_sync_i(loop_sync), .regen_pin_i(regen_pin), .req_i(req),
    .tx_o(tx), .ind_o(ind), .loop1_o(loop1), .traffic_o(traffic),
    .ctl_lb2_o(ctl_lb2), .ctl_lb1a_o(ctl_lb1a), .act_late_o(act_late)
  );

  lta_nt_model nt (
    .core_clk(core_clk), .tx_i(tx), .loop1_i(loop1), .mute(mute),
    .dly(dly), .rx_o(rx), .rx_lock_o(rx_lock), .loop_sync_o(loop_sync)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [10:0] ev(input logic en,
    input lta_tx_code_t c, input logic [4:0] f, input logic lp,
    input logic tr);
    return {en, c, f, lp, tr};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      errors++;
      $display("[ERR] %0t saw %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic ex(input logic [10:0] v, input int g);
    exp_q.push_back(v);
    gap_q.push_back(g);
  endtask

  task automatic rq(input logic [4:0] b);
    req = b;
    @(negedge core_clk);
    req = '0;
  endtask

  task automatic drain();
    for (int k = 0; k < 20000 && exp_q.size() != 0; k++)
      @(negedge core_clk);
    check(exp_q.size(), 0);
    exp_q.delete();
    gap_q.delete();
    repeat (4) @(negedge core_clk);
  endtask

  task automatic up();
    ex(ev(1'b1, LTA_TX_SIG2, 5'h08, 1'b0, 1'b0), 0);
    ex(ev(1'b1, LTA_TX_SIG4H, 5'h00, 1'b0, 1'b0), 0);
    ex(ev(1'b1, LTA_TX_SIG4, 5'h04, 1'b0, 1'b1), MS);
    drain();
    check(act_late, 1'b0);
  endtask

  task automatic lb_up(input int g);
    ex(ev(1'b1, LTA_TX_SIG4H, 5'h00, 1'b1, 1'b0), g);
    ex(ev(1'b1, LTA_TX_SIG4, 5'h04, 1'b1, 1'b1), MS);
    drain();
  endtask

  task automatic deact();
    ex(ev(1'b1, LTA_TX_SIG0, 5'h00, 1'b0, 1'b0), 0);
    ex(ev(1'b0, LTA_TX_SIG0, 5'h02, 1'b0, 1'b0), 0);
    rq(5'h08);
    drain();
  endtask

  task automatic lost();
    rx_frame_lost = 1'b1;
    @(negedge core_clk);
    rx_frame_lost = 1'b0;
  endtask

  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Every change of tx or pulse on ind must match the oldest queued note
  always @(negedge core_clk)
  begin
    if (!sys_rst)
    begin
      cyc++;
      if (tx !== prev_tx || ind !== 5'h00)
      begin
        if (exp_q.size() == 0)
          check(32'h1, 32'h0);
        else
        begin
          check({tx, ind, loop1, traffic}, exp_q.pop_front());
          mon_gap = gap_q.pop_front();
          if (mon_gap != 0)
            check(cyc - last, mon_gap);
        end
        last = cyc;
      end
      prev_tx = tx;
    end
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end

  initial
  begin
    sys_rst = 1'b1;
    regen_pin = 1'b0;
    rx_frame_lost = 1'b0;
    mute = 1'b0;
    dly = 4'h2;
    req = '0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    check(tx, 4'h0);
    // Far end never answers, so the first-power limit runs out
    mute = 1'b1;
    ex(ev(1'b1, LTA_TX_SIG2W, 5'h00, 1'b0, 1'b0), 0);
    rq(5'h10);
    repeat (1500 * MS - 3) @(negedge core_clk);
    check(act_late, 1'b0);
    repeat (6) @(negedge core_clk);
    check(act_late, 1'b1);
    deact();
    check(act_late, 1'b0);
    mute = 1'b0;
    dly = 4'h1 + 4'($unsigned($random(seed)) % 6);
    ex(ev(1'b1, LTA_TX_SIG2W, 5'h00, 1'b0, 1'b0), 0);
    ex(ev(1'b1, LTA_TX_SIG2, 5'h10, 1'b0, 1'b0), 0);
    rq(5'h10);
    up();
    // Stray requests while active must leave the line alone
    for (i = 0; i < 24; i++)
    begin
      req = 5'($random(seed)) & 5'h17;
      @(negedge core_clk);
      check(ctl_lb2, req.lb2);
      check(ctl_lb1a, req.lb1a);
      check(traffic, 1'b1);
    end
    req = '0;
    repeat (2) @(negedge core_clk);
    ex(ev(1'b1, LTA_TX_SIG2, 5'h01, 1'b0, 1'b0), 0);
    lost();
    up();
    deact();
    dly = 4'h1 + 4'($unsigned($random(seed)) % 6);
    ex(ev(1'b1, LTA_TX_SIG2W, 5'h10, 1'b0, 1'b0), 0);
    ex(ev(1'b1, LTA_TX_SIG2, 5'h00, 1'b0, 1'b0), 40 + 7 * MS);
    nt.wake_cnt = 3;
    up();
    deact();
    // Loopback request together with activation request
    ex(ev(1'b1, LTA_TX_SIG2W, 5'h00, 1'b0, 1'b0), 0);
    ex(ev(1'b1, LTA_TX_SIG2, 5'h00, 1'b1, 1'b0), 12 * MS);
    rq(5'h14);
    lb_up(0);
    ex(ev(1'b1, LTA_TX_SIG2, 5'h01, 1'b1, 1'b0), 0);
    lost();
    lb_up(1);
    deact();
    // Regenerator strap with a silent far end: redo limit doubles
    regen_pin = 1'b1;
    mute = 1'b1;
    ex(ev(1'b1, LTA_TX_SIG2W, 5'h00, 1'b0, 1'b0), 0);
    rq(5'h10);
    repeat (420 * MS - 3) @(negedge core_clk);
    check(act_late, 1'b0);
    repeat (6) @(negedge core_clk);
    check(act_late, 1'b1);
    deact();
    report_and_stop();
  end
endmodule

`default_nettype wire
